/* spl_framer.sv */
// Device-side serial packet framer: receiver, command hand-off, answers and reports.
//
// Contract
// - Line runs 115200 baud, eight data bits, no parity, one stop bit.
// - Packet order is type, length, payload, then check value.
// - Type byte holds two class bits above a six-bit code.
// - Class 00 is host command, 01 response, 10 unsolicited report.
// - Well-formed packet with illegal content is answered with class 11.
// - Length counts payload bytes; only 0 to 22 is valid.
// - Check value is 16-bit CRC over type, length and payload.
// - Check value goes on the line low byte first.
// - Check value follows last payload byte, or length byte if empty.
// - No flow-control lines or characters; pacing is by acknowledge only.
// - Every received packet is answered within 250 ms; bad-length, bad-check and non-command packets and a command during a pending one go unanswered.
// - Enabled reports are sent on their own; three kinds exist.
// - Answer code bits equal the code bits of the acknowledged command.
`timescale 1ns/1ps
module spl_framer #(
  parameter int RESP_TIMEOUT_CYC = spl_pkg::RESP_TO_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       rxd,
  output logic            txd,
  output logic            cmd_valid,
  output logic [5:0]      cmd_code,
  output logic [4:0]      cmd_len,
  input  wire logic [4:0] cmd_idx,
  output logic [7:0]      cmd_byte,
  input  wire logic       ans_valid,
  input  wire logic       ans_err,
  input  wire logic [4:0] ans_len,
  output logic            ans_taken,
  output logic            timeout_err,
  input  wire logic [7:0] pay_data,
  input  wire logic       pay_valid,
  output logic            pay_ready,
  input  wire logic       rpt_en,
  input  wire logic       rpt_valid,
  input  wire logic [1:0] rpt_kind,
  input  wire logic [4:0] rpt_len,
  output logic            rpt_taken
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic              rx_m_r, rx_s_r, rx_d_r;
  logic [10:0]       rcnt_r;
  logic [3:0]        rbit_r;
  logic              rbusy_r;
  logic [7:0]        rsh_r;
  logic              rxb_v_r;
  spl_pkg::spl_rx_st_t rx_st_r;
  logic [7:0]        r_type_r;
  logic [4:0]        r_len_r;
  logic [4:0]        r_idx_r;
  logic [15:0]       r_crc_r;
  logic [7:0]        r_clo_r;
  logic [7:0]        rx_buf [0:21];
  logic [15:0]       r_crc_nxt;
  logic              pkt_good;
  logic              pkt_take;
  logic              len_bad;
  logic [24:0]       rt_cnt_r;
  logic              auto_err_r;
  spl_pkg::spl_tx_st_t tx_st_r;
  logic [7:0]        t_type_r;
  logic [4:0]        t_len_r;
  logic [4:0]        t_idx_r;
  logic [15:0]       t_crc_r;
  logic [9:0]        tsh_r;
  logic [10:0]       tcnt_r;
  logic [3:0]        tbits_r;
  logic              u_idle;
  logic              tx_go;
  logic [7:0]        tx_byte;
  logic [15:0]       t_crc_fin;
  logic              take_ans;
  logic              take_rpt;
  logic [7:0]        f_data;
  logic              f_valid;
  logic              f_pop;

  function automatic logic [4:0] clamp_len(input logic [4:0] l);
    return (l > 5'(spl_pkg::MAX_LEN)) ? 5'(spl_pkg::MAX_LEN) : l;
  endfunction : clamp_len

  // ------------------------------------------------------------
  // Serial receiver
  // ------------------------------------------------------------
  // No flow-control pins exist; the host paces itself on acknowledges.
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_m_r  <= 1'b1;
      rx_s_r  <= 1'b1;
      rx_d_r  <= 1'b1;
      rbusy_r <= 1'b0;
      rcnt_r  <= '0;
      rbit_r  <= '0;
      rsh_r   <= '0;
      rxb_v_r <= 1'b0;
    end else begin
      rx_m_r  <= rxd;
      rx_s_r  <= rx_m_r;
      rx_d_r  <= rx_s_r;
      rxb_v_r <= 1'b0;
      if (!rbusy_r) begin
        if (rx_d_r && !rx_s_r) begin
          rbusy_r <= 1'b1;
          rcnt_r  <= spl_pkg::HALF_CYC;
          rbit_r  <= '0;
        end
      end else if (rcnt_r != '0) begin
        rcnt_r <= rcnt_r - 11'h001;
      end else begin
        rcnt_r <= spl_pkg::BIT_CYC - 11'h001;
        rbit_r <= rbit_r + 4'h1;
        if (rbit_r == '0 && rx_s_r) begin
          rbusy_r <= 1'b0;
        end else if (rbit_r == spl_pkg::STOP_IDX) begin
          rbusy_r <= 1'b0;
          rxb_v_r <= rx_s_r;
        end else if (rbit_r != '0) begin
          rsh_r <= {rx_s_r, rsh_r[7:1]};
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Packet parser
  // ------------------------------------------------------------
  assign r_crc_nxt = spl_pkg::crc_byte(r_crc_r, rsh_r);
  assign len_bad   = rsh_r > spl_pkg::MAX_LEN;
  assign pkt_good  = {rsh_r, r_clo_r} == (r_crc_r ^ spl_pkg::CRC_XOR);
  // A command arriving while one is still unanswered is dropped; hosts must wait.
  assign pkt_take  = rxb_v_r && rx_st_r == spl_pkg::RX_CHI && pkt_good && !cmd_valid
                     && r_type_r[7:6] == spl_pkg::CLS_CMD;

  always_ff @(posedge clk) begin
    if (rxb_v_r && rx_st_r == spl_pkg::RX_DATA && !cmd_valid) begin
      rx_buf[r_idx_r] <= rsh_r;
    end
    cmd_byte <= rx_buf[cmd_idx];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_st_r  <= spl_pkg::RX_TYPE;
      r_type_r <= '0;
      r_len_r  <= '0;
      r_idx_r  <= '0;
      r_crc_r  <= spl_pkg::CRC_INIT;
      r_clo_r  <= '0;
      cmd_code <= '0;
      cmd_len  <= '0;
    end else if (rxb_v_r) begin
      unique case (rx_st_r)
        spl_pkg::RX_TYPE: begin
          r_type_r <= rsh_r;
          r_crc_r  <= spl_pkg::crc_byte(spl_pkg::CRC_INIT, rsh_r);
          rx_st_r  <= spl_pkg::RX_LEN;
        end
        spl_pkg::RX_LEN: begin
          r_len_r <= rsh_r[4:0];
          r_idx_r <= '0;
          r_crc_r <= r_crc_nxt;
          if (len_bad) begin
            rx_st_r <= spl_pkg::RX_TYPE;
          end else if (rsh_r == 8'h00) begin
            rx_st_r <= spl_pkg::RX_CLO;
          end else begin
            rx_st_r <= spl_pkg::RX_DATA;
          end
        end
        spl_pkg::RX_DATA: begin
          r_crc_r <= r_crc_nxt;
          r_idx_r <= r_idx_r + 5'h01;
          if (r_idx_r == r_len_r - 5'h01) begin
            rx_st_r <= spl_pkg::RX_CLO;
          end
        end
        spl_pkg::RX_CLO: begin
          r_clo_r <= rsh_r;
          rx_st_r <= spl_pkg::RX_CHI;
        end
        spl_pkg::RX_CHI: begin
          rx_st_r <= spl_pkg::RX_TYPE;
          if (pkt_take) begin
            cmd_code <= r_type_r[5:0];
            cmd_len  <= r_len_r;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pending command and answer deadline
  // ------------------------------------------------------------
  // The deadline sits short of 250 ms so that a report already on the line
  // and the fallback error packet still finish in time.
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_valid  <= 1'b0;
      rt_cnt_r   <= '0;
      auto_err_r <= 1'b0;
    end else begin
      if (pkt_take) begin
        cmd_valid <= 1'b1;
      end else if (take_ans) begin
        cmd_valid <= 1'b0;
      end
      if (!cmd_valid || take_ans) begin
        rt_cnt_r   <= '0;
        auto_err_r <= 1'b0;
      end else if (rt_cnt_r == 25'(RESP_TIMEOUT_CYC - 1)) begin
        auto_err_r <= 1'b1;
      end else begin
        rt_cnt_r <= rt_cnt_r + 25'h0000001;
      end
    end
  end

  // ------------------------------------------------------------
  // Transmit framing
  // ------------------------------------------------------------
  assign u_idle    = tbits_r == '0 && tcnt_r == '0;
  assign take_ans  = tx_st_r == spl_pkg::TX_IDLE && cmd_valid && (ans_valid || auto_err_r);
  assign take_rpt  = tx_st_r == spl_pkg::TX_IDLE && !take_ans && rpt_en && rpt_valid
                     && rpt_kind < spl_pkg::RPT_KINDS;
  assign tx_go     = tx_st_r != spl_pkg::TX_IDLE && u_idle
                     && (tx_st_r != spl_pkg::TX_DATA || f_valid);
  assign f_pop     = tx_go && tx_st_r == spl_pkg::TX_DATA;
  assign t_crc_fin = t_crc_r ^ spl_pkg::CRC_XOR;
  assign tx_byte   = (tx_st_r == spl_pkg::TX_TYPE) ? t_type_r :
                     (tx_st_r == spl_pkg::TX_LEN)  ? {3'h0, t_len_r} :
                     (tx_st_r == spl_pkg::TX_DATA) ? f_data :
                     (tx_st_r == spl_pkg::TX_CLO)  ? t_crc_fin[7:0] : t_crc_fin[15:8];

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_st_r     <= spl_pkg::TX_IDLE;
      t_type_r    <= '0;
      t_len_r     <= '0;
      t_idx_r     <= '0;
      t_crc_r     <= spl_pkg::CRC_INIT;
      ans_taken   <= 1'b0;
      timeout_err <= 1'b0;
      rpt_taken   <= 1'b0;
    end else begin
      ans_taken   <= take_ans && ans_valid;
      timeout_err <= take_ans && !ans_valid;
      rpt_taken   <= take_rpt;
      if (take_ans) begin
        t_type_r <= {(ans_valid && !ans_err) ? spl_pkg::CLS_RSP : spl_pkg::CLS_ERR,
                     cmd_code};
        t_len_r  <= ans_valid ? clamp_len(ans_len) : 5'h00;
        t_crc_r  <= spl_pkg::CRC_INIT;
        tx_st_r  <= spl_pkg::TX_TYPE;
      end else if (take_rpt) begin
        t_type_r <= {spl_pkg::CLS_RPT, 4'h0, rpt_kind};
        t_len_r  <= clamp_len(rpt_len);
        t_crc_r  <= spl_pkg::CRC_INIT;
        tx_st_r  <= spl_pkg::TX_TYPE;
      end else if (tx_go) begin
        unique case (tx_st_r)
          spl_pkg::TX_TYPE: begin
            t_crc_r <= spl_pkg::crc_byte(t_crc_r, tx_byte);
            tx_st_r <= spl_pkg::TX_LEN;
          end
          spl_pkg::TX_LEN: begin
            t_crc_r <= spl_pkg::crc_byte(t_crc_r, tx_byte);
            t_idx_r <= '0;
            tx_st_r <= (t_len_r == '0) ? spl_pkg::TX_CLO : spl_pkg::TX_DATA;
          end
          spl_pkg::TX_DATA: begin
            t_crc_r <= spl_pkg::crc_byte(t_crc_r, tx_byte);
            t_idx_r <= t_idx_r + 5'h01;
            if (t_idx_r == t_len_r - 5'h01) begin
              tx_st_r <= spl_pkg::TX_CLO;
            end
          end
          spl_pkg::TX_CLO: tx_st_r <= spl_pkg::TX_CHI;
          default:         tx_st_r <= spl_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Serial transmitter
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      txd     <= 1'b1;
      tsh_r   <= '1;
      tcnt_r  <= '0;
      tbits_r <= '0;
    end else if (tx_go) begin
      tsh_r   <= {1'b1, tx_byte, 1'b0};
      tbits_r <= spl_pkg::FRAME_BITS;
      tcnt_r  <= '0;
    end else if (tbits_r != '0 && tcnt_r == '0) begin
      txd     <= tsh_r[0];
      tsh_r   <= {1'b1, tsh_r[9:1]};
      tbits_r <= tbits_r - 4'h1;
      tcnt_r  <= spl_pkg::BIT_CYC - 11'h001;
    end else if (tcnt_r != '0) begin
      tcnt_r <= tcnt_r - 11'h001;
    end
  end

  // Payload FIFO lets the user side run ahead; it stalls on a busy line.
  spl_fifo #(
    .W (spl_pkg::FIFO_W),
    .D (spl_pkg::FIFO_D)
  ) u_pay_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (pay_data),
    .in_valid  (pay_valid),
    .in_ready  (pay_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  int unsigned pend_age;
  always_ff @(posedge clk) begin
    pend_age <= (rst || !cmd_valid) ? 0 : pend_age + 1;
  end

  property p_type_then_len;
    @(posedge clk) disable iff (rst)
    tx_go && tx_st_r == spl_pkg::TX_TYPE |=> tx_st_r == spl_pkg::TX_LEN;
  endproperty
  a_type_then_len: assert property (p_type_then_len) else $error("length must follow type");

  property p_no_cmd_class;
    @(posedge clk) disable iff (rst)
    tx_go && tx_st_r == spl_pkg::TX_TYPE |-> tx_byte[7:6] != spl_pkg::CLS_CMD;
  endproperty
  a_no_cmd_class: assert property (p_no_cmd_class) else $error("device sent command class");

  property p_err_class;
    @(posedge clk) disable iff (rst)
    take_ans && (ans_err || !ans_valid) |=> t_type_r[7:6] == spl_pkg::CLS_ERR;
  endproperty
  a_err_class: assert property (p_err_class) else $error("illegal content not answered as error");

  property p_len_bound;
    @(posedge clk) disable iff (rst)
    tx_st_r != spl_pkg::TX_IDLE |-> t_len_r <= 5'(spl_pkg::MAX_LEN);
  endproperty
  a_len_bound: assert property (p_len_bound) else $error("sent length above limit");

  property p_crc_lo_first;
    @(posedge clk) disable iff (rst)
    tx_go && tx_st_r == spl_pkg::TX_CLO |=> tx_st_r == spl_pkg::TX_CHI ##1 !u_idle;
  endproperty
  a_crc_lo_first: assert property (p_crc_lo_first) else $error("check bytes out of order");

  property p_resp_time;
    @(posedge clk) disable iff (rst)
    cmd_valid |-> pend_age < RESP_TIMEOUT_CYC + 300 * 10 * spl_pkg::BIT_CYC;
  endproperty
  a_resp_time: assert property (p_resp_time) else $error("answer deadline missed");

  property p_code_echo;
    @(posedge clk) disable iff (rst)
    take_ans |=> t_type_r[5:0] == $past(cmd_code);
  endproperty
  a_code_echo: assert property (p_code_echo) else $error("answer code mismatch");

  property p_bad_len_drop;
    @(posedge clk) disable iff (rst)
    rxb_v_r && rx_st_r == spl_pkg::RX_LEN && len_bad |=> rx_st_r == spl_pkg::RX_TYPE;
  endproperty
  a_bad_len_drop: assert property (p_bad_len_drop) else $error("bad length not dropped");

  property p_rpt_gate;
    @(posedge clk) disable iff (rst)
    rpt_taken |-> $past(rpt_en) && t_type_r[7:6] == spl_pkg::CLS_RPT;
  endproperty
  a_rpt_gate: assert property (p_rpt_gate) else $error("report sent while disabled");

  property p_start_bit;
    @(posedge clk) disable iff (rst)
    tx_go |=> ##1 !txd;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("missing start bit");

  c_cmd_taken: cover property (@(posedge clk) disable iff (rst) pkt_take);
  c_ans_sent: cover property (@(posedge clk) disable iff (rst) ans_taken);
  c_timeout: cover property (@(posedge clk) disable iff (rst) timeout_err);
  c_report: cover property (@(posedge clk) disable iff (rst) rpt_taken);
endmodule : spl_framer

/* spl_pkg.sv */
// Shared constants, types and the check-value function of the serial packet link framer.
package spl_pkg;
  // ------------------------------------------------------------
  // Line timing
  // ------------------------------------------------------------
  localparam int          CLK_HZ       = 125_000_000;
  localparam int          BAUD         = 115_200;
  localparam logic [10:0] BIT_CYC      = 11'(CLK_HZ / BAUD);
  localparam logic [10:0] HALF_CYC     = 11'(CLK_HZ / BAUD / 2);
  localparam logic [3:0]  FRAME_BITS   = 4'hA;
  localparam logic [3:0]  STOP_IDX     = 4'h9;
  localparam int          RESP_MS      = 250;
  localparam int          RESP_CYC     = CLK_HZ / 1000 * RESP_MS;
  // Room left for a report already on the line plus the error packet.
  localparam int          GUARD_CYC    = 600 * (CLK_HZ / BAUD);
  localparam int          RESP_TO_CYC  = RESP_CYC - GUARD_CYC;
  // ------------------------------------------------------------
  // Packet fields
  // ------------------------------------------------------------
  localparam logic [1:0]  CLS_CMD      = 2'h0;
  localparam logic [1:0]  CLS_RSP      = 2'h1;
  localparam logic [1:0]  CLS_RPT      = 2'h2;
  localparam logic [1:0]  CLS_ERR      = 2'h3;
  localparam logic [7:0]  MAX_LEN      = 8'h16;
  localparam logic [1:0]  RPT_KINDS    = 2'h3;
  localparam int          FIFO_W       = 8;
  localparam int          FIFO_D       = 16;
  localparam logic [15:0] CRC_INIT     = 16'hFFFF;
  localparam logic [15:0] CRC_POLY     = 16'h8408;
  localparam logic [15:0] CRC_XOR      = 16'hFFFF;

  typedef enum logic [4:0] {
    RX_TYPE = 5'b00001, RX_LEN = 5'b00010, RX_DATA = 5'b00100,
    RX_CLO  = 5'b01000, RX_CHI = 5'b10000
  } spl_rx_st_t;

  typedef enum logic [5:0] {
    TX_IDLE = 6'b000001, TX_TYPE = 6'b000010, TX_LEN = 6'b000100,
    TX_DATA = 6'b001000, TX_CLO  = 6'b010000, TX_CHI = 6'b100000
  } spl_tx_st_t;

  // Reflected CRC step over one byte, least significant bit first.
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte
endpackage : spl_pkg

/* spl_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module spl_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [0:D-1];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          push;
  logic          pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_ready && out_valid;
  assign cnt_nxt   = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data  = mem[rp_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r      <= '0;
      rp_r      <= '0;
      cnt_r     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wp_r      <= wp_r + AW'(push);
      rp_r      <= rp_r + AW'(pop);
      cnt_r     <= cnt_nxt;
      in_ready  <= cnt_nxt != (AW + 1)'(D);
      out_valid <= cnt_nxt != '0;
    end
  end
endmodule : spl_fifo

/* spl_host.sv */
// Host-side serial model: sends packets on rxd and collects the bytes seen on txd.
`timescale 1ns/1ps
module spl_host (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  // ------------------------------------------------------------
  // Line model
  // ------------------------------------------------------------
  // Bytes are queued as they arrive, so no report is lost while a test waits.
  logic [7:0] rx_q[$];
  int         frame_errs = 0;

  initial rxd = 1'b1;

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[k]) begin
      c = c ^ {8'h00, q[k]};
      for (int i = 0; i < 8; i++) begin
        c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
      end
    end
    return c ^ 16'hFFFF;
  endfunction : crc16

  task automatic put_bit(input logic v);
    rxd = v;
    repeat (spl_pkg::BIT_CYC) @(negedge clk);
  endtask : put_bit

  // The bench sends a new command only once the previous one is answered.
  // A set bad flag spoils the check value, so the device must stay silent.
  task automatic send_pkt(input logic [7:0] q[$], input bit bad = 1'b0);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0] ^ {7'h00, bad});
    q.push_back(c[15:8]);
    foreach (q[k]) begin
      put_bit(1'b0);
      for (int i = 0; i < 8; i++) put_bit(q[k][i]);
      put_bit(1'b1);
    end
  endtask : send_pkt

  // Sampling on the falling edge keeps clear of the registered txd update.
  always begin : rx_proc
    logic [7:0] b;
    @(negedge txd);
    repeat (spl_pkg::HALF_CYC) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (spl_pkg::BIT_CYC) @(negedge clk);
      b[i] = txd;
    end
    repeat (spl_pkg::BIT_CYC) @(negedge clk);
    if (txd !== 1'b1) frame_errs++;
    rx_q.push_back(b);
  end
endmodule : spl_host

/* tb.sv */
// Self-checking bench for the serial packet link framer.
`timescale 1ns/1ps
module tb;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       rxd;
  logic       txd;
  logic       cmd_valid;
  logic [5:0] cmd_code;
  logic [4:0] cmd_len;
  logic [4:0] cmd_idx = 5'h00;
  logic [7:0] cmd_byte;
  logic       ans_valid = 1'b0;
  logic       ans_err = 1'b0;
  logic [4:0] ans_len = 5'h00;
  logic       ans_taken;
  logic       timeout_err;
  logic [7:0] pay_data = 8'h00;
  logic       pay_valid = 1'b0;
  logic       pay_ready;
  logic       rpt_en = 1'b0;
  logic       rpt_valid = 1'b0;
  logic [1:0] rpt_kind = 2'h0;
  logic [4:0] rpt_len = 5'h00;
  logic       rpt_taken;
  int         fails = 0;
  int         total_checks = 0;

  always #4 clk = ~clk;

  spl_framer #(.RESP_TIMEOUT_CYC(60000)) spl_framer_inst (
    .clk(clk), .rst(rst), .rxd(rxd), .txd(txd), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_len(cmd_len), .cmd_idx(cmd_idx), .cmd_byte(cmd_byte),
    .ans_valid(ans_valid), .ans_err(ans_err), .ans_len(ans_len), .ans_taken(ans_taken),
    .timeout_err(timeout_err), .pay_data(pay_data), .pay_valid(pay_valid),
    .pay_ready(pay_ready), .rpt_en(rpt_en), .rpt_valid(rpt_valid), .rpt_kind(rpt_kind),
    .rpt_len(rpt_len), .rpt_taken(rpt_taken)
  );

  spl_host spl_host_inst (.clk(clk), .txd(txd), .rxd(rxd));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("FAIL t=%0t %s", $time, msg);
    end
  endtask : check

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // A wait that runs out is a mismatch and ends the run.
  task automatic wait_hi(ref logic s, input int lim, input string what);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (s !== 1'b1) begin
      fails++;
      $display("FAIL t=%0t timeout %s", $time, what);
      end_sim();
    end
  endtask : wait_hi

  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (spl_host_inst.rx_q.size() < n && k < 70000) begin
      @(negedge clk);
      k++;
    end
    if (spl_host_inst.rx_q.size() < n) begin
      fails++;
      $display("FAIL t=%0t timeout on line bytes", $time);
      end_sim();
    end
  endtask : wait_rx

  task automatic chk_pkt(input logic [7:0] e[$], input string what);
    logic [15:0] c;
    c = spl_host_inst.crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    wait_rx(e.size());
    foreach (e[k]) check(spl_host_inst.rx_q[k] === e[k], what);
    spl_host_inst.rx_q.delete();
    check(spl_host_inst.frame_errs == 0, "stop bit");
  endtask : chk_pkt

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    check(txd === 1'b1 && cmd_valid === 1'b0, "idle after reset");
    check(pay_ready === 1'b1, "fifo ready after reset");
    rpt_en = 1'b1;
    rpt_valid = 1'b1;
    rpt_kind = 2'h3;
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      check(rpt_taken === 1'b0, "report kind 3 refused");
    end
    rpt_valid = 1'b0;
    @(negedge clk);
    $display("test reset done");
  endtask : t_reset

  // A report goes out while the command comes in, so they overlap.
  task automatic t_cmd_and_report;
    fork
      spl_host_inst.send_pkt('{8'h05, 8'h01, 8'hA5});
      begin
        rpt_en = 1'b1;
        rpt_valid = 1'b1;
        rpt_kind = 2'h2;
        rpt_len = 5'h00;
        wait_hi(rpt_taken, 20, "report taken");
        rpt_valid = 1'b0;
      end
    join
    wait_hi(cmd_valid, 3000, "command seen");
    check(cmd_code === 6'h05 && cmd_len === 5'h01, "command fields");
    check(cmd_byte === 8'hA5, "command payload byte");
    chk_pkt('{8'h82, 8'h00}, "report packet");
    $display("test command and report done");
  endtask : t_cmd_and_report

  task automatic t_fifo_and_error;
    int n;
    n = 0;
    for (int i = 0; i < 17; i++) begin
      @(negedge clk);
      if (pay_ready !== 1'b1) break;
      pay_data = 8'h10 + 8'(i);
      pay_valid = 1'b1;
      @(posedge clk);
      n++;
    end
    pay_valid = 1'b0;
    check(n == 16, "fifo depth");
    ans_valid = 1'b1;
    ans_err = 1'b1;
    ans_len = 5'h01;
    wait_hi(ans_taken, 20, "answer taken");
    ans_valid = 1'b0;
    check(timeout_err === 1'b0, "user answer is not a timeout");
    check(cmd_valid === 1'b0, "command released");
    // A spoiled command rides in while the answer goes out; it must not be taken.
    fork
      spl_host_inst.send_pkt('{8'h07, 8'h00}, 1'b1);
      begin
        wait_hi(pay_ready, 40000, "fifo drain");
        chk_pkt('{8'hC5, 8'h01, 8'h10}, "error answer");
      end
    join
    check(cmd_valid === 1'b0, "bad check value not dropped");
    $display("test fifo and error answer done");
  endtask : t_fifo_and_error

  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_reset();
    t_cmd_and_report();
    t_fifo_and_error();
    end_sim();
  end
endmodule : tb
